// ===== core/bsa_defines.vh
// constants for the block search and 8-bit alu execution unit
//==========================================================
// What this block does
// (RULE_01) forward search compares accumulator with pointed byte
// (RULE_02) forward step: pointer up, counter down
// (RULE_03) repeat until match or counter zero
// (RULE_04) backward variants decrement the pointer instead
// (RULE_05) alu ops combine accumulator and source operand
// (RULE_06) compare updates flags, accumulator unchanged
// (RULE_07) every alu op updates the flags
// (RULE_08) inc and dec write back to source
// (RULE_09) index displacement byte follows the opcode
// (RULE_10) immediate operand byte follows the opcode
// (RULE_11) sixteen-bit values arrive low byte first
// (RULE_12) pointer addresses byte, counter pair counts
// (RULE_13) search only reads, match is exact equality
`ifndef BSA_DEFINES_VH
`define BSA_DEFINES_VH
//==========================================================
// command codes
`define BSA_CMD_NONE     4'h0
`define BSA_CMD_ADD      4'h1
`define BSA_CMD_ADC      4'h2
`define BSA_CMD_SUB      4'h3
`define BSA_CMD_SBC      4'h4
`define BSA_CMD_AND      4'h5
`define BSA_CMD_XOR      4'h6
`define BSA_CMD_OR       4'h7
`define BSA_CMD_CMP      4'h8
`define BSA_CMD_INC      4'h9
`define BSA_CMD_DEC      4'ha
`define BSA_CMD_SUP      4'hb
`define BSA_CMD_SRUP     4'hc
`define BSA_CMD_SDN      4'hd
`define BSA_CMD_SRDN     4'he
//==========================================================
// source selection
`define BSA_SRC_REG      2'h0
`define BSA_SRC_PTR      2'h1
`define BSA_SRC_IDX      2'h2
`define BSA_SRC_IMM      2'h3
//==========================================================
// flag bit positions
`define BSA_F_CARRY      0
`define BSA_F_SUB        1
`define BSA_F_PV         2
`define BSA_F_HALF       4
`define BSA_F_ZERO       6
`define BSA_F_SIGN       7
//==========================================================
// reset values
`define BSA_RST_ACC      8'h00
`define BSA_RST_FLAGS    8'h00
`define BSA_RST_WORD     16'h0000
`endif

// ===== core/bsa_alu.v
// combinational 8-bit alu with flag generation
`timescale 1ns/1ps
`include "bsa_defines.vh"
module bsa_alu (
    input  wire [3:0] cmd,
    input  wire [7:0] accIn,
    input  wire [7:0] opIn,
    input  wire       carryIn,
    output reg  [7:0] result,
    output reg  [7:0] flagsOut,
    output reg        writeAcc
);
    reg [8:0] sum;
    reg [4:0] half;
    reg       ovf;
    reg       isSub;
    always @* begin
        sum      = 9'h000;
        half     = 5'h00;
        ovf      = 1'b0;
        isSub    = 1'b0;
        writeAcc = 1'b1;
        result   = 8'h00;
        case (cmd)
            `BSA_CMD_ADD, `BSA_CMD_ADC: begin
                sum  = {1'b0, accIn} + {1'b0, opIn} + {8'h00, (cmd == `BSA_CMD_ADC) & carryIn};
                half = {1'b0, accIn[3:0]} + {1'b0, opIn[3:0]}
                       + {4'h0, (cmd == `BSA_CMD_ADC) & carryIn};
                ovf  = (accIn[7] == opIn[7]) && (sum[7] != accIn[7]);
            end
            `BSA_CMD_SUB, `BSA_CMD_SBC, `BSA_CMD_CMP: begin
                isSub = 1'b1;
                sum  = {1'b0, accIn} - {1'b0, opIn} - {8'h00, (cmd == `BSA_CMD_SBC) & carryIn};
                half = {1'b0, accIn[3:0]} - {1'b0, opIn[3:0]}
                       - {4'h0, (cmd == `BSA_CMD_SBC) & carryIn};
                ovf  = (accIn[7] != opIn[7]) && (sum[7] != accIn[7]);
                if (cmd == `BSA_CMD_CMP) begin
                    writeAcc = 1'b0; // RULE_06
                end
            end
            `BSA_CMD_AND: begin
                sum  = {1'b0, accIn & opIn};
                half = 5'h10;
            end
            `BSA_CMD_XOR: sum = {1'b0, accIn ^ opIn};
            `BSA_CMD_OR:  sum = {1'b0, accIn | opIn};
            // in-place ops: accumulator is not the second operand
            `BSA_CMD_INC: begin
                sum      = {1'b0, opIn} + 9'h001; // RULE_08
                half     = {1'b0, opIn[3:0]} + 5'h01;
                ovf      = (opIn == 8'h7f);
                writeAcc = 1'b0;
            end
            `BSA_CMD_DEC: begin
                isSub    = 1'b1;
                sum      = {1'b0, opIn} - 9'h001; // RULE_08
                half     = {1'b0, opIn[3:0]} - 5'h01;
                ovf      = (opIn == 8'h80);
                writeAcc = 1'b0;
            end
            default: writeAcc = 1'b0;
        endcase
        result = sum[7:0]; // RULE_05
        flagsOut = 8'h00;
        flagsOut[`BSA_F_SIGN] = sum[7]; // RULE_07
        flagsOut[`BSA_F_ZERO] = (sum[7:0] == 8'h00);
        flagsOut[`BSA_F_HALF] = half[4];
        flagsOut[`BSA_F_SUB]  = isSub;
        if (cmd == `BSA_CMD_AND || cmd == `BSA_CMD_XOR || cmd == `BSA_CMD_OR) begin
            flagsOut[`BSA_F_PV] = ~^sum[7:0];
        end else begin
            flagsOut[`BSA_F_PV] = ovf;
        end
        // inc and dec keep the old carry
        if (cmd == `BSA_CMD_INC || cmd == `BSA_CMD_DEC) begin
            flagsOut[`BSA_F_CARRY] = carryIn;
        end else begin
            flagsOut[`BSA_F_CARRY] = sum[8];
        end
    end
endmodule // bsa_alu

// ===== core/bsa_exec.v
// execution unit: operand fetch, 8-bit alu group and block search
`timescale 1ns/1ps
`include "bsa_defines.vh"
module bsa_exec (
    input  wire        ref_clk,
    input  wire        rst_b,
    input  wire        cmdValid,
    input  wire [3:0]  cmdCode,
    input  wire [1:0]  cmdSrc,
    input  wire [7:0]  cmdRegVal,
    input  wire [15:0] idxBase,
    input  wire        ldValid,
    input  wire [1:0]  ldSel,
    input  wire [15:0] ldWord,
    input  wire [15:0] fetchPc,
    input  wire        memAck,
    input  wire [7:0]  memRdata,
    output reg         memRd_r,
    output reg         memWr_r,
    output reg  [15:0] memAddr_r,
    output reg  [7:0]  memWdata_r,
    output reg  [7:0]  acc_r,
    output reg  [7:0]  flags_r,
    output reg  [15:0] memPtr_r,
    output reg  [15:0] byteCnt_r,
    output reg  [7:0]  regOut_r,
    output reg         regWr_r,
    output reg  [15:0] nextPc_r,
    output reg         busy_r,
    output reg         done_r
);
//==========================================================
// reset release
    // assert at once, release on the clock so no flop leaves reset early
    reg rstS1;
    reg rstS2;
    always @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            rstS1 <= 1'b0;
            rstS2 <= 1'b0;
        end else begin
            rstS1 <= 1'b1;
            rstS2 <= rstS1;
        end
    end
    wire rstN = rstS2;
//==========================================================
// states
    localparam ST_IDLE  = 3'h0;
    localparam ST_FETCH = 3'h1;
    localparam ST_ARG   = 3'h2;
    localparam ST_READ  = 3'h3;
    localparam ST_EXEC  = 3'h4;
    localparam ST_WRITE = 3'h5;
    localparam ST_FIN   = 3'h6;
    reg [2:0]  state_r;
    reg [3:0]  cmd_r;
    reg [1:0]  src_r;
    reg [7:0]  opnd_r;
    reg [15:0] eaddr_r;
    function isSearch;
        input [3:0] c;
        begin
            isSearch = (c == `BSA_CMD_SUP) || (c == `BSA_CMD_SRUP)
                       || (c == `BSA_CMD_SDN) || (c == `BSA_CMD_SRDN);
        end
    endfunction
//==========================================================
// alu
    wire [7:0] aluRes;
    wire [7:0] aluFlags;
    wire       aluWrAcc;
    bsa_alu uAlu (
        .cmd      (isSearch(cmd_r) ? `BSA_CMD_CMP : cmd_r),
        .accIn    (acc_r),
        .opIn     (opnd_r),
        .carryIn  (flags_r[`BSA_F_CARRY]),
        .result   (aluRes),
        .flagsOut (aluFlags),
        .writeAcc (aluWrAcc)
    );
//==========================================================
// search step
    // a count of zero at the start of a repeat search wraps, so 65536 bytes are searched
    wire        down    = (cmd_r == `BSA_CMD_SDN) || (cmd_r == `BSA_CMD_SRDN);
    wire        rpt     = (cmd_r == `BSA_CMD_SRUP) || (cmd_r == `BSA_CMD_SRDN);
    wire [15:0] cntNxt  = byteCnt_r - 16'h0001;
    wire        match   = (acc_r == opnd_r); // RULE_13
    wire [15:0] dispExt = {{8{memRdata[7]}}, memRdata};
    // search keeps carry; parity slot tells whether bytes remain
    wire [7:0]  srchFlags = {aluFlags[7:3], (cntNxt != 16'h0000),
                             aluFlags[1], flags_r[`BSA_F_CARRY]};
//==========================================================
// sequencer
    always @(posedge ref_clk or negedge rstN) begin
        if (!rstN) begin
            state_r    <= ST_IDLE;
            cmd_r      <= `BSA_CMD_NONE;
            src_r      <= `BSA_SRC_REG;
            opnd_r     <= 8'h00;
            eaddr_r    <= `BSA_RST_WORD;
            memRd_r    <= 1'b0;
            memWr_r    <= 1'b0;
            memAddr_r  <= `BSA_RST_WORD;
            memWdata_r <= 8'h00;
            acc_r      <= `BSA_RST_ACC;
            flags_r    <= `BSA_RST_FLAGS;
            memPtr_r   <= `BSA_RST_WORD;
            byteCnt_r  <= `BSA_RST_WORD;
            regOut_r   <= 8'h00;
            regWr_r    <= 1'b0;
            nextPc_r   <= `BSA_RST_WORD;
            busy_r     <= 1'b0;
            done_r     <= 1'b0;
        end else begin
            done_r  <= 1'b0;
            regWr_r <= 1'b0;
            case (state_r)
                ST_IDLE: begin
                    // a load wins over a command in the same cycle
                    if (ldValid) begin
                        // 16-bit words are assembled low byte first upstream
                        case (ldSel) // RULE_11
                            2'h0: memPtr_r  <= ldWord;
                            2'h1: byteCnt_r <= ldWord; // RULE_12
                            2'h2: acc_r     <= ldWord[7:0];
                            default: flags_r <= ldWord[7:0];
                        endcase
                    end else if (cmdValid && cmdCode != `BSA_CMD_NONE) begin
                        cmd_r    <= cmdCode;
                        src_r    <= cmdSrc;
                        opnd_r   <= cmdRegVal;
                        nextPc_r <= fetchPc;
                        busy_r   <= 1'b1;
                        if (isSearch(cmdCode)) begin
                            state_r <= ST_READ;
                        end else if (cmdSrc == `BSA_SRC_IDX || cmdSrc == `BSA_SRC_IMM) begin
                            state_r <= ST_FETCH;
                        end else if (cmdSrc == `BSA_SRC_PTR) begin
                            eaddr_r <= memPtr_r;
                            state_r <= ST_READ;
                        end else begin
                            state_r <= ST_EXEC;
                        end
                    end
                end
                ST_FETCH: begin
                    // byte right after the opcode
                    memRd_r   <= 1'b1;
                    memAddr_r <= nextPc_r; // RULE_09 RULE_10
                    state_r   <= ST_ARG;
                end
                ST_ARG: begin
                    // ack only counts while the read is still raised
                    if (memRd_r && memAck) begin
                        memRd_r  <= 1'b0;
                        nextPc_r <= nextPc_r + 16'h0001;
                        if (src_r == `BSA_SRC_IMM) begin
                            opnd_r  <= memRdata; // RULE_10
                            state_r <= ST_EXEC;
                        end else begin
                            eaddr_r <= idxBase + dispExt; // RULE_09
                            state_r <= ST_READ;
                        end
                    end
                end
                ST_READ: begin
                    memRd_r   <= 1'b1;
                    memAddr_r <= isSearch(cmd_r) ? memPtr_r : eaddr_r; // RULE_01 RULE_12
                    if (memRd_r && memAck) begin
                        memRd_r <= 1'b0;
                        opnd_r  <= memRdata;
                        state_r <= ST_EXEC;
                    end
                end
                ST_EXEC: begin
                    if (isSearch(cmd_r)) begin
                        // search never writes memory; only flags, pointer and count change
                        flags_r   <= srchFlags; // RULE_01 RULE_13
                        memPtr_r  <= down ? memPtr_r - 16'h0001 // RULE_04
                                          : memPtr_r + 16'h0001; // RULE_02
                        byteCnt_r <= cntNxt; // RULE_02
                        if (rpt && !match && cntNxt != 16'h0000) begin
                            state_r <= ST_READ; // RULE_03
                        end else begin
                            state_r <= ST_FIN;
                        end
                    end else begin
                        flags_r <= aluFlags; // RULE_07
                        if (aluWrAcc) begin
                            acc_r <= aluRes; // RULE_05 RULE_06
                        end
                        if (cmd_r == `BSA_CMD_INC || cmd_r == `BSA_CMD_DEC) begin
                            if (src_r == `BSA_SRC_REG) begin
                                regOut_r <= aluRes; // RULE_08
                                regWr_r  <= 1'b1;
                                state_r  <= ST_FIN;
                            end else begin
                                memWr_r    <= 1'b1;
                                memAddr_r  <= eaddr_r; // RULE_08
                                memWdata_r <= aluRes;
                                state_r    <= ST_WRITE;
                            end
                        end else begin
                            state_r <= ST_FIN;
                        end
                    end
                end
                ST_WRITE: begin
                    // ack only counts while the write is still raised
                    if (memWr_r && memAck) begin
                        memWr_r <= 1'b0;
                        state_r <= ST_FIN;
                    end
                end
                default: begin
                    busy_r  <= 1'b0;
                    done_r  <= 1'b1;
                    state_r <= ST_IDLE;
                end
            endcase
        end
    end
endmodule // bsa_exec

// ===== test/bsa_exec_props.sv
// concurrent checks on the execution unit ports
`timescale 1ns/1ps
`include "bsa_defines.vh"
module bsa_exec_props (
    input wire        ref_clk,
    input wire        rst_b,
    input wire        cmdValid,
    input wire [3:0]  cmdCode,
    input wire [1:0]  cmdSrc,
    input wire        ldValid,
    input wire [15:0] fetchPc,
    input wire        memAck,
    input wire        memRd_r,
    input wire        memWr_r,
    input wire [15:0] memAddr_r,
    input wire [7:0]  acc_r,
    input wire [7:0]  flags_r,
    input wire [15:0] memPtr_r,
    input wire [15:0] byteCnt_r,
    input wire        regWr_r,
    input wire [15:0] nextPc_r,
    input wire        busy_r,
    input wire        done_r
);
//==========================================
// snapshot taken at the command's take edge
reg  [61:0] snap_r;
wire        take = !busy_r && cmdValid && !ldValid && cmdCode != 4'h0;
wire [3:0]  cmd  = snap_r[61:58];
wire        srch = cmd >= `BSA_CMD_SUP;
wire [15:0] ptr0 = snap_r[47:32];
wire [15:0] cnt0 = snap_r[31:16];
always @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b)
        snap_r <= 62'h0;
    else if (take)
        snap_r <= {cmdCode, cmdSrc, acc_r, memPtr_r, byteCnt_r, fetchPc};
end
//==========================================
// properties
default clocking @(posedge ref_clk); endclocking
default disable iff (!rst_b);
done_pulse_a: assert property (done_r |=> !done_r)
    else $error("done held too long");
reg_latency_a: assert property (take && cmdSrc == `BSA_SRC_REG && cmdCode < `BSA_CMD_SUP
    |-> ##[1:3] done_r) else $error("register op late");
rd_hold_a: assert property (memRd_r && !memAck |=> memRd_r && $stable(memAddr_r))
    else $error("read dropped before ack");
srch_addr_a: assert property (busy_r && srch && memRd_r |-> memAddr_r == memPtr_r)
    else $error("search read off pointer");
srch_ro_a: assert property (busy_r && srch |-> !memWr_r)
    else $error("search wrote memory");
step_up_a: assert property (done_r && cmd == `BSA_CMD_SUP
    |-> memPtr_r == ptr0 + 16'h1 && byteCnt_r == cnt0 - 16'h1) else $error("up step bad");
step_dn_a: assert property (done_r && cmd == `BSA_CMD_SDN
    |-> memPtr_r == ptr0 - 16'h1 && byteCnt_r == cnt0 - 16'h1) else $error("down step bad");
rep_stop_a: assert property (done_r && (cmd == `BSA_CMD_SRUP || cmd == `BSA_CMD_SRDN)
    |-> flags_r[`BSA_F_ZERO] || byteCnt_r == 16'h0) else $error("repeat stopped early");
acc_kept_a: assert property (done_r && cmd >= `BSA_CMD_CMP && cmd <= `BSA_CMD_DEC
    |-> acc_r == snap_r[55:48]) else $error("accumulator changed");
arg_pc_a: assert property (done_r && snap_r[57] && !srch
    |-> nextPc_r == snap_r[15:0] + 16'h1) else $error("next pc wrong");
wr_pulse_a: assert property (regWr_r |=> !regWr_r)
    else $error("register write held");
endmodule // bsa_exec_props
bind bsa_exec bsa_exec_props i_bsa_exec_props (.ref_clk(ref_clk), .rst_b(rst_b),
    .cmdValid(cmdValid), .cmdCode(cmdCode), .cmdSrc(cmdSrc), .ldValid(ldValid),
    .fetchPc(fetchPc), .memAck(memAck), .memRd_r(memRd_r), .memWr_r(memWr_r),
    .memAddr_r(memAddr_r), .acc_r(acc_r), .flags_r(flags_r), .memPtr_r(memPtr_r),
    .byteCnt_r(byteCnt_r), .regWr_r(regWr_r), .nextPc_r(nextPc_r), .busy_r(busy_r),
    .done_r(done_r));

// ===== test/bsa_mem_model.sv
// behavioural memory on the far side of the execution unit
`timescale 1ns/1ps
module bsa_mem_model (
    input wire        ref_clk,
    input wire        memRd_r,
    input wire        memWr_r,
    input wire [15:0] memAddr_r,
    input wire [7:0]  memWdata_r,
    input wire [1:0]  waitCyc,
    output reg        memAck,
    output reg [7:0]  memRdata
);
reg [7:0] mem [0:65535];
reg [1:0] cnt;
initial begin
    memAck = 1'b0;
    memRdata = 8'h00;
    cnt = 2'h0;
end
// idle data toggles so a stale sample never looks right
always @(posedge ref_clk) begin
    memAck <= 1'b0;
    memRdata <= ~memRdata;
    if ((memRd_r || memWr_r) && !memAck) begin
        cnt <= (cnt == waitCyc) ? 2'h0 : cnt + 2'h1;
        if (cnt == waitCyc) begin
            memAck <= 1'b1;
            memRdata <= mem[memAddr_r];
            if (memWr_r)
                mem[memAddr_r] <= memWdata_r;
        end
    end
end
endmodule // bsa_mem_model

// ===== test/tb_top.sv
// self-checking bench for the execution unit
`timescale 1ns/1ps
`include "bsa_defines.vh"
module tb_top;
reg ref_clk, rst_b, cmdValid, ldValid;
reg [3:0] cmdCode, c;
reg [1:0] cmdSrc, ldSel, waitCyc;
reg [7:0] cmdRegVal, a, b, f;
reg [15:0] idxBase, ldWord, fetchPc;
reg [8:0] e;
wire memAck, memRd_r, memWr_r, regWr_r, busy_r, done_r;
wire [7:0] memRdata, memWdata_r, acc_r, flags_r, regOut_r;
wire [15:0] memAddr_r, memPtr_r, byteCnt_r, nextPc_r;
integer error_cnt, n_tests, seed, i, k;
bsa_exec i_bsa_exec (.ref_clk(ref_clk), .rst_b(rst_b), .cmdValid(cmdValid),
    .cmdCode(cmdCode), .cmdSrc(cmdSrc), .cmdRegVal(cmdRegVal), .idxBase(idxBase),
    .ldValid(ldValid), .ldSel(ldSel), .ldWord(ldWord), .fetchPc(fetchPc),
    .memAck(memAck), .memRdata(memRdata), .memRd_r(memRd_r), .memWr_r(memWr_r),
    .memAddr_r(memAddr_r), .memWdata_r(memWdata_r), .acc_r(acc_r), .flags_r(flags_r),
    .memPtr_r(memPtr_r), .byteCnt_r(byteCnt_r), .regOut_r(regOut_r),
    .regWr_r(regWr_r), .nextPc_r(nextPc_r), .busy_r(busy_r), .done_r(done_r));
bsa_mem_model i_bsa_mem_model (.ref_clk(ref_clk), .memRd_r(memRd_r),
    .memWr_r(memWr_r), .memAddr_r(memAddr_r), .memWdata_r(memWdata_r),
    .waitCyc(waitCyc), .memAck(memAck), .memRdata(memRdata));
//==========================================
// clock, checks and bus tasks
initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
end
function [8:0] alu(input [3:0] op, input [7:0] x, input [7:0] y, input ci);
    case (op)
        `BSA_CMD_ADD: alu = x + y;
        `BSA_CMD_ADC: alu = x + y + ci;
        `BSA_CMD_SBC: alu = {1'b0, x} - y - ci;
        `BSA_CMD_AND: alu = x & y;
        `BSA_CMD_XOR: alu = x ^ y;
        `BSA_CMD_OR:  alu = x | y;
        default:      alu = {1'b0, x} - y;
    endcase
endfunction
task chk(input [15:0] got, input [15:0] exp);
    begin
        n_tests = n_tests + 1;
        if (got !== exp) begin
            error_cnt = error_cnt + 1;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    end
endtask
task chkb(input got, input exp);
    begin
        chk({15'h0, got}, {15'h0, exp});
    end
endtask
task ld(input [1:0] s, input [15:0] w);
    begin
        @(posedge ref_clk);
        ldValid <= 1'b1;
        ldSel <= s;
        ldWord <= w;
        @(posedge ref_clk);
        ldValid <= 1'b0;
    end
endtask
// one-cycle command, then wait for done with a bound
task run(input [3:0] op, input [1:0] s, input [7:0] r);
    begin
        @(posedge ref_clk);
        cmdValid <= 1'b1;
        cmdCode <= op;
        cmdSrc <= s;
        cmdRegVal <= r;
        waitCyc <= 2'($random(seed));
        @(posedge ref_clk);
        cmdValid <= 1'b0;
        i = 0;
        while (done_r !== 1'b1 && i < 300) begin
            @(negedge ref_clk);
            i = i + 1;
        end
        chkb(i < 300, 1'b1);
        chkb(busy_r, 1'b0);
    end
endtask
task finish_test;
    begin
        if (error_cnt == 0 && n_tests > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    end
endtask
//==========================================
// watchdog and main sequence
initial begin
    #3000000;
    error_cnt = error_cnt + 1;
    finish_test;
end
initial begin
    {rst_b, cmdValid, ldValid, cmdCode, cmdSrc, ldSel, waitCyc} = 0;
    {cmdRegVal, idxBase, ldWord} = 0;
    {error_cnt, n_tests} = 0;
    seed = 32'ha5e02946;
    fetchPc = 16'h1200;
    repeat (20) @(posedge ref_clk);
    rst_b <= 1'b1;
    repeat (3) @(posedge ref_clk);
    for (k = 0; k < 40; k = k + 1) begin
        c = 4'h1 + {1'b0, 3'($random(seed))};
        a = $random(seed);
        b = $random(seed);
        f = $random(seed);
        ld(2'h2, {8'h0, a});
        ld(2'h3, {8'h0, f});
        run(c, `BSA_SRC_REG, b);
        e = alu(c, a, b, f[0]);
        chk({8'h0, acc_r}, {8'h0, (c == `BSA_CMD_CMP) ? a : e[7:0]});
        chkb(flags_r[`BSA_F_ZERO], e[7:0] == 8'h0);
        chkb(flags_r[`BSA_F_SIGN], e[7]);
        chkb(flags_r[`BSA_F_SUB],
             c == `BSA_CMD_SUB || c == `BSA_CMD_SBC || c == `BSA_CMD_CMP);
        if (c <= `BSA_CMD_SBC)
            chkb(flags_r[`BSA_F_CARRY], e[8]);
    end
    i_bsa_mem_model.mem[16'h1200] = 8'h07;
    ld(2'h2, 16'h00f3);
    run(`BSA_CMD_AND, `BSA_SRC_IMM, 8'h00);
    chk({8'h0, acc_r}, 16'h0003);
    chk(nextPc_r, 16'h1201);
    i_bsa_mem_model.mem[16'h1200] = 8'hfe;
    i_bsa_mem_model.mem[16'h2ffe] = 8'h11;
    idxBase <= 16'h3000;
    ld(2'h2, 16'h0022);
    run(`BSA_CMD_ADD, `BSA_SRC_IDX, 8'h00);
    chk({8'h0, acc_r}, 16'h0033);
    run(`BSA_CMD_INC, `BSA_SRC_REG, 8'hff);
    chk({8'h0, regOut_r}, 16'h0000);
    chkb(flags_r[`BSA_F_ZERO], 1'b1);
    for (k = 0; k < 16; k = k + 1)
        i_bsa_mem_model.mem[16'h5000 + k] = k;
    i_bsa_mem_model.mem[16'h5003] = 8'h5a;
    ld(2'h0, 16'h5000);
    run(`BSA_CMD_DEC, `BSA_SRC_PTR, 8'h00);
    chk({8'h0, i_bsa_mem_model.mem[16'h5000]}, 16'h00ff);
    ld(2'h1, 16'h000a);
    ld(2'h2, 16'h005a);
    run(`BSA_CMD_SUP, `BSA_SRC_REG, 8'h00);
    chk(memPtr_r, 16'h5001);
    chk(byteCnt_r, 16'h0009);
    chkb(flags_r[`BSA_F_PV], 1'b1);
    run(`BSA_CMD_SRUP, `BSA_SRC_REG, 8'h00);
    chk(memPtr_r, 16'h5004);
    chk(byteCnt_r, 16'h0006);
    chkb(flags_r[`BSA_F_ZERO], 1'b1);
    chk({8'h0, i_bsa_mem_model.mem[16'h5003]}, 16'h005a);
    run(`BSA_CMD_SDN, `BSA_SRC_REG, 8'h00);
    chk(memPtr_r, 16'h5003);
    chkb(flags_r[`BSA_F_ZERO], 1'b0);
    ld(2'h1, 16'h0003);
    ld(2'h0, 16'h5009);
    run(`BSA_CMD_SRDN, `BSA_SRC_REG, 8'h00);
    chk(memPtr_r, 16'h5006);
    chk(byteCnt_r, 16'h0000);
    chkb(flags_r[`BSA_F_PV], 1'b0);
    chkb(flags_r[`BSA_F_ZERO], 1'b0);
    finish_test;
end
endmodule // tb_top
